// ==== shared/energy_pulse_pkg.sv ====
// Package for the energy pulse source configuration block.
// Holds register offsets, field positions, reset values and encodings.
// Assumes AXI4-Lite access with 32-bit data and word-aligned registers.
package energy_pulse_pkg;

    // -------------------------------------------------------------------
    // Register map (indexes; byte address is four times the index)
    // -------------------------------------------------------------------
    localparam logic [15:0] COMP_MODE_INDEX   = 16'he60e;
    localparam logic [15:0] PULSE_SRC_INDEX   = 16'he610;
    localparam logic [15:0] NOM_VOLT_INDEX    = 16'he533;
    localparam int          ADDR_WIDTH        = 18;

    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [15:0] COMP_MODE_RESET   = 16'h01ff;
    localparam logic [15:0] PULSE_SRC_RESET   = 16'h0088;
    localparam logic [23:0] NOM_VOLT_RESET    = 24'h000000;

    // -------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------
    localparam int SEL_ONE_LSB     = 0;
    localparam int SEL_TWO_LSB     = 3;
    localparam int SEL_THREE_LSB   = 6;
    localparam int ANGLE_LSB       = 9;
    localparam int NOM_A_BIT       = 11;
    localparam int NOM_B_BIT       = 12;
    localparam int NOM_C_BIT       = 13;
    localparam int FREQ_BIT        = 14;
    localparam int SPARE_BIT       = 15;
    localparam int NOM_VOLT_WIDTH  = 24;

    // -------------------------------------------------------------------
    // Encodings
    // -------------------------------------------------------------------
    localparam logic [2:0] SRC_TOTAL_ACTIVE   = 3'h0;
    localparam logic [2:0] SRC_TOTAL_REACTIVE = 3'h1;
    localparam logic [2:0] SRC_APPARENT       = 3'h2;
    localparam logic [2:0] SRC_FUND_ACTIVE    = 3'h3;
    localparam logic [2:0] SRC_FUND_REACTIVE  = 3'h4;
    localparam logic [2:0] SRC_NONE           = 3'h7;

    localparam logic [1:0] ANGLE_VOLT_CURR    = 2'h0;
    localparam logic [1:0] ANGLE_VOLTS        = 2'h1;
    localparam logic [1:0] ANGLE_CURRS        = 2'h2;
    localparam logic [1:0] ANGLE_OFF          = 2'h3;

    localparam logic [1:0] AXI_OKAY           = 2'h0;
    localparam logic [1:0] AXI_SLVERR         = 2'h2;

endpackage

// ==== verilog/energy_pulse_source_config.sv ====
// Configuration registers of a polyphase energy meter pulse path.
// Assumes a single 10 MHz clock, AXI4-Lite master on the same clock, and
// per-phase measurement results fed in synchronously by the meter core.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Phase include bits A, B, C for output three sit at bits 6, 7, 8 and reset to one.
// - With all three include bits of output three set, output three uses the sum over all phases.
// - Field 10:9 resets to 00 and picks volt-current, volt-volt, current-current or no delay measurement.
// - Nominal-voltage enable bits 11, 12, 13 reset to zero and, while clear, apparent power is Vrms times Irms.
// - With a nominal-voltage enable bit set, that phase's apparent power is Irms times the nominal voltage value.
// - Bit 14 resets to zero and selects a 50 Hz network when clear and 60 Hz when set.
// - Bit 15 of the computation mode register resets to zero and controls nothing.
// - Source field one, reset 000, picks total active, total reactive, apparent, fund. active or fund. reactive.
// - Source field one holding 101 to 111 suppresses output one.
// - Source field two uses the same codes, resets to 001, and reserved codes suppress output two.
// - Source field three uses the same codes and resets to 010, apparent power.
// - Bits 2:0 and 5:3 are include bits for outputs one and two, each reset to one, 111 meaning all phases.
module energy_pulse_source_config #(
    parameter int POWER_WIDTH = 24
) (
    input  wire logic                          clock_i,
    input  wire logic                          reset_i,
    // AXI4-Lite slave
    input  wire logic [17:0]                   s_axi_awaddr_i,
    input  wire logic                          s_axi_awvalid_i,
    output logic                               s_axi_awready_o,
    input  wire logic [31:0]                   s_axi_wdata_i,
    input  wire logic [3:0]                    s_axi_wstrb_i,
    input  wire logic                          s_axi_wvalid_i,
    output logic                               s_axi_wready_o,
    output logic [1:0]                         s_axi_bresp_o,
    output logic                               s_axi_bvalid_o,
    input  wire logic                          s_axi_bready_i,
    input  wire logic [17:0]                   s_axi_araddr_i,
    input  wire logic                          s_axi_arvalid_i,
    output logic                               s_axi_arready_o,
    output logic [31:0]                        s_axi_rdata_o,
    output logic [1:0]                         s_axi_rresp_o,
    output logic                               s_axi_rvalid_o,
    input  wire logic                          s_axi_rready_i,
    // Per-phase results from the meter core, index 0 = A
    input  wire logic                          update_i,
    input  wire logic [3*POWER_WIDTH-1:0]      total_active_i,
    input  wire logic [3*POWER_WIDTH-1:0]      total_reactive_i,
    input  wire logic [3*POWER_WIDTH-1:0]      fund_active_i,
    input  wire logic [3*POWER_WIDTH-1:0]      fund_reactive_i,
    input  wire logic [3*POWER_WIDTH-1:0]      volt_rms_i,
    input  wire logic [3*POWER_WIDTH-1:0]      curr_rms_i,
    // Selected sums feeding the energy-to-frequency converters
    output logic signed [POWER_WIDTH+1:0]      pulse_power_one_o,
    output logic signed [POWER_WIDTH+1:0]      pulse_power_two_o,
    output logic signed [POWER_WIDTH+1:0]      pulse_power_three_o,
    output logic [2:0]                         pulse_enable_o,
    output logic [1:0]                         angle_measure_select_o,
    output logic                               line_frequency_select_o
);

    localparam int PW = POWER_WIDTH;
    localparam int SW = POWER_WIDTH + 2;

    // -------------------------------------------------------------------
    // Parameter check
    // -------------------------------------------------------------------
    if (POWER_WIDTH < 8 || POWER_WIDTH > 32)
    begin : g_width_check
        $error("POWER_WIDTH must lie between 8 and 32");
    end

    // -------------------------------------------------------------------
    // Registers and bus state
    // -------------------------------------------------------------------
    logic [15:0]                 comp_mode_q;
    logic [15:0]                 pulse_src_q;
    logic [23:0]                 nominal_voltage_value_q;
    logic                        aw_held_q;
    logic                        w_held_q;
    logic [17:0]                 awaddr_q;
    logic [31:0]                 wdata_q;
    logic [3:0]                  wstrb_q;
    logic                        do_write;
    logic [15:0]                 waddr_index;
    logic [15:0]                 raddr_index;

    // Byte address to register index
    function automatic logic [15:0] to_index(input logic [17:0] addr);
        to_index = addr[17:2];
    endfunction

    // Merge byte lanes into a register value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[8*i +: 8] = data[8*i +: 8];
            end
        end
        merge = res;
    endfunction

    // Sum one quantity over the included phases
    function automatic logic signed [SW-1:0] phase_sum(input logic [3*PW-1:0] vals,
                                                       input logic [2:0] incl);
        logic signed [SW-1:0] acc;
        acc = '0;
        for (int p = 0; p < 3; p++)
        begin
            if (incl[p])
            begin
                acc = acc + SW'(signed'(vals[p*PW +: PW]));
            end
        end
        phase_sum = acc;
    endfunction

    // Pick the quantity named by a source code
    function automatic logic signed [SW-1:0] pick(input logic [2:0] code,
                                                  input logic signed [SW-1:0] ta,
                                                  input logic signed [SW-1:0] tr,
                                                  input logic signed [SW-1:0] ap,
                                                  input logic signed [SW-1:0] fa,
                                                  input logic signed [SW-1:0] fr);
        case (code)
            energy_pulse_pkg::SRC_TOTAL_ACTIVE:   pick = ta;
            energy_pulse_pkg::SRC_TOTAL_REACTIVE: pick = tr;
            energy_pulse_pkg::SRC_APPARENT:       pick = ap;
            energy_pulse_pkg::SRC_FUND_ACTIVE:    pick = fa;
            energy_pulse_pkg::SRC_FUND_REACTIVE:  pick = fr;
            default:                              pick = '0;
        endcase
    endfunction

    assign do_write    = aw_held_q && w_held_q && !s_axi_bvalid_o;
    assign waddr_index = to_index(awaddr_q);
    assign raddr_index = to_index(s_axi_araddr_i);

    // -------------------------------------------------------------------
    // AXI4-Lite write channels: address and data captured in any order
    // -------------------------------------------------------------------
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            aw_held_q       <= 1'b0;
            w_held_q        <= 1'b0;
            awaddr_q        <= '0;
            wdata_q         <= '0;
            wstrb_q         <= '0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o  <= 1'b0;
        end
        else
        begin
            s_axi_awready_o <= !aw_held_q && !s_axi_awready_o && !s_axi_bvalid_o;
            s_axi_wready_o  <= !w_held_q && !s_axi_wready_o && !s_axi_bvalid_o;
            if (s_axi_awvalid_i && s_axi_awready_o)
            begin
                aw_held_q       <= 1'b1;
                awaddr_q        <= s_axi_awaddr_i;
                s_axi_awready_o <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o)
            begin
                w_held_q       <= 1'b1;
                wdata_q        <= s_axi_wdata_i;
                wstrb_q        <= s_axi_wstrb_i;
                s_axi_wready_o <= 1'b0;
            end
            if (do_write)
            begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
            end
        end
    end

    // Write response, error for unmapped index
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= energy_pulse_pkg::AXI_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid_o <= 1'b1;
            if (waddr_index == energy_pulse_pkg::COMP_MODE_INDEX ||
                waddr_index == energy_pulse_pkg::PULSE_SRC_INDEX ||
                waddr_index == energy_pulse_pkg::NOM_VOLT_INDEX)
            begin
                s_axi_bresp_o <= energy_pulse_pkg::AXI_OKAY;
            end
            else
            begin
                s_axi_bresp_o <= energy_pulse_pkg::AXI_SLVERR;
            end
        end
        else if (s_axi_bready_i)
        begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // Configuration registers; each write touches only its own register
    // -------------------------------------------------------------------
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            comp_mode_q             <= energy_pulse_pkg::COMP_MODE_RESET;
            pulse_src_q             <= energy_pulse_pkg::PULSE_SRC_RESET;
            nominal_voltage_value_q <= energy_pulse_pkg::NOM_VOLT_RESET;
        end
        else if (do_write)
        begin
            if (waddr_index == energy_pulse_pkg::COMP_MODE_INDEX)
            begin
                comp_mode_q <= 16'(merge({16'h0000, comp_mode_q}, wdata_q, wstrb_q));
            end
            if (waddr_index == energy_pulse_pkg::PULSE_SRC_INDEX)
            begin
                pulse_src_q <= 16'(merge({16'h0000, pulse_src_q}, wdata_q, wstrb_q));
            end
            if (waddr_index == energy_pulse_pkg::NOM_VOLT_INDEX)
            begin
                nominal_voltage_value_q <= 24'(merge({8'h00, nominal_voltage_value_q}, wdata_q, wstrb_q));
            end
        end
    end

    // -------------------------------------------------------------------
    // AXI4-Lite read channel
    // -------------------------------------------------------------------
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= '0;
            s_axi_rresp_o   <= energy_pulse_pkg::AXI_OKAY;
        end
        else
        begin
            s_axi_arready_o <= !s_axi_arready_o && !s_axi_rvalid_o;
            if (s_axi_arvalid_i && s_axi_arready_o)
            begin
                s_axi_arready_o <= 1'b0;
                s_axi_rvalid_o  <= 1'b1;
                s_axi_rresp_o   <= energy_pulse_pkg::AXI_OKAY;
                case (raddr_index)
                    energy_pulse_pkg::COMP_MODE_INDEX: s_axi_rdata_o <= {16'h0000, comp_mode_q};
                    energy_pulse_pkg::PULSE_SRC_INDEX: s_axi_rdata_o <= {16'h0000, pulse_src_q};
                    energy_pulse_pkg::NOM_VOLT_INDEX:  s_axi_rdata_o <= {8'h00, nominal_voltage_value_q};
                    default:
                    begin
                        s_axi_rdata_o <= '0;
                        s_axi_rresp_o <= energy_pulse_pkg::AXI_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rvalid_o && s_axi_rready_i)
            begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------------
    // Datapath: apparent power per phase and selected sums
    // -------------------------------------------------------------------
    logic [2:0]           nominal_use;
    logic [3*PW-1:0]      apparent;
    logic [2:0]           phase_select_out_one;
    logic [2:0]           phase_select_out_two;
    logic [2:0]           phase_select_out_three;
    logic [2:0]           source_select_out_one;
    logic [2:0]           source_select_out_two;
    logic [2:0]           source_select_out_three;

    assign nominal_use = {comp_mode_q[energy_pulse_pkg::NOM_C_BIT],
                          comp_mode_q[energy_pulse_pkg::NOM_B_BIT],
                          comp_mode_q[energy_pulse_pkg::NOM_A_BIT]};
    assign phase_select_out_one    = comp_mode_q[energy_pulse_pkg::SEL_ONE_LSB +: 3];
    assign phase_select_out_two    = comp_mode_q[energy_pulse_pkg::SEL_TWO_LSB +: 3];
    assign phase_select_out_three  = comp_mode_q[energy_pulse_pkg::SEL_THREE_LSB +: 3];
    assign source_select_out_one   = pulse_src_q[energy_pulse_pkg::SEL_ONE_LSB +: 3];
    assign source_select_out_two   = pulse_src_q[energy_pulse_pkg::SEL_TWO_LSB +: 3];
    assign source_select_out_three = pulse_src_q[energy_pulse_pkg::SEL_THREE_LSB +: 3];

    // Apparent power: measured or nominal voltage times rms current, top bits kept
    always_comb
    begin
        logic [2*PW-1:0] prod;
        prod     = '0;
        apparent = '0;
        for (int p = 0; p < 3; p++)
        begin
            if (nominal_use[p])
            begin
                prod = curr_rms_i[p*PW +: PW] * PW'(nominal_voltage_value_q);
            end
            else
            begin
                prod = curr_rms_i[p*PW +: PW] * volt_rms_i[p*PW +: PW];
            end
            apparent[p*PW +: PW] = {1'b0, prod[2*PW-1 -: PW-1]};
        end
    end

    // Output sums, refreshed only on a computation update
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            pulse_power_one_o   <= '0;
            pulse_power_two_o   <= '0;
            pulse_power_three_o <= '0;
        end
        else if (update_i)
        begin
            pulse_power_one_o <= pick(source_select_out_one,
                phase_sum(total_active_i, phase_select_out_one), phase_sum(total_reactive_i, phase_select_out_one),
                phase_sum(apparent, phase_select_out_one), phase_sum(fund_active_i, phase_select_out_one),
                phase_sum(fund_reactive_i, phase_select_out_one));
            pulse_power_two_o <= pick(source_select_out_two,
                phase_sum(total_active_i, phase_select_out_two), phase_sum(total_reactive_i, phase_select_out_two),
                phase_sum(apparent, phase_select_out_two), phase_sum(fund_active_i, phase_select_out_two),
                phase_sum(fund_reactive_i, phase_select_out_two));
            pulse_power_three_o <= pick(source_select_out_three,
                phase_sum(total_active_i, phase_select_out_three),
                phase_sum(total_reactive_i, phase_select_out_three),
                phase_sum(apparent, phase_select_out_three), phase_sum(fund_active_i, phase_select_out_three),
                phase_sum(fund_reactive_i, phase_select_out_three));
        end
    end

    // Mode outputs and pulse enables, refreshed on a computation update
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            pulse_enable_o          <= 3'h7;
            angle_measure_select_o  <= energy_pulse_pkg::ANGLE_VOLT_CURR;
            line_frequency_select_o <= 1'b0;
        end
        else if (update_i)
        begin
            pulse_enable_o <= {source_select_out_three <= energy_pulse_pkg::SRC_FUND_REACTIVE,
                               source_select_out_two <= energy_pulse_pkg::SRC_FUND_REACTIVE,
                               source_select_out_one <= energy_pulse_pkg::SRC_FUND_REACTIVE};
            angle_measure_select_o  <= comp_mode_q[energy_pulse_pkg::ANGLE_LSB +: 2];
            line_frequency_select_o <= comp_mode_q[energy_pulse_pkg::FREQ_BIT];
        end
    end

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    sequence s_update;
        update_i;
    endsequence

    AST_RESERVED_SUPPRESS: assert property (@(posedge clock_i) disable iff (reset_i)
        s_update and (source_select_out_one > energy_pulse_pkg::SRC_FUND_REACTIVE) |=> !pulse_enable_o[0])
        else $error("output one enabled with reserved code");
    AST_TWO_SUPPRESS: assert property (@(posedge clock_i) disable iff (reset_i)
        s_update and (source_select_out_two > energy_pulse_pkg::SRC_FUND_REACTIVE)
        |=> !pulse_enable_o[1] && pulse_power_two_o == '0)
        else $error("output two enabled with reserved code");
    AST_FREQ_FOLLOW: assert property (@(posedge clock_i) disable iff (reset_i)
        s_update |=> line_frequency_select_o == $past(comp_mode_q[energy_pulse_pkg::FREQ_BIT]))
        else $error("frequency select not applied");
    AST_ANGLE_FOLLOW: assert property (@(posedge clock_i) disable iff (reset_i)
        s_update |=> angle_measure_select_o == $past(comp_mode_q[energy_pulse_pkg::ANGLE_LSB +: 2]))
        else $error("angle select not applied");
    AST_HOLD_NO_UPDATE: assert property (@(posedge clock_i) disable iff (reset_i)
        !update_i |=> $stable(pulse_power_one_o) && $stable(angle_measure_select_o))
        else $error("outputs changed without update");
    AST_SPARE_READ: assert property (@(posedge clock_i) disable iff (reset_i)
        (s_axi_arvalid_i && s_axi_arready_o && raddr_index == energy_pulse_pkg::COMP_MODE_INDEX)
        |=> s_axi_rvalid_o && s_axi_rdata_o[15:0] == $past(comp_mode_q))
        else $error("computation mode read back wrong");
    AST_SRC_READ: assert property (@(posedge clock_i) disable iff (reset_i)
        (s_axi_arvalid_i && s_axi_arready_o && raddr_index == energy_pulse_pkg::PULSE_SRC_INDEX)
        |=> s_axi_rdata_o == {16'h0000, $past(pulse_src_q)})
        else $error("source select read back wrong");
    AST_ALL_PHASES_THREE: assert property (@(posedge clock_i) disable iff (reset_i)
        s_update and phase_select_out_three == 3'h7 and source_select_out_three == energy_pulse_pkg::SRC_TOTAL_ACTIVE
        |=> pulse_power_three_o == $past(SW'(signed'(total_active_i[0 +: PW])) + SW'(signed'(total_active_i[PW +: PW]))
            + SW'(signed'(total_active_i[2*PW +: PW]))))
        else $error("output three not the three-phase sum");

endmodule

`default_nettype wire

// ==== testbench/tb.sv ====
// Testbench for the energy pulse source configuration block.
// Assumes the block alone, reached over AXI4-Lite and its update port.
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ----------------------------------------------------------------
    // Signals and reference data
    // ----------------------------------------------------------------
    localparam logic [15:0] CM = energy_pulse_pkg::COMP_MODE_INDEX;
    localparam logic [15:0] SR = energy_pulse_pkg::PULSE_SRC_INDEX;
    localparam logic [15:0] NV = energy_pulse_pkg::NOM_VOLT_INDEX;
    logic clock_i = 0, reset_i = 1, update_i = 0;
    logic [17:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0;
    logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o;
    logic [3:0] s_axi_wstrb_i = 4'hf;
    logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0, s_axi_arvalid_i = 0, s_axi_rready_i = 0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, angle_measure_select_o;
    logic [71:0] total_active_i, total_reactive_i, fund_active_i, fund_reactive_i, volt_rms_i, curr_rms_i;
    logic signed [25:0] pulse_power_one_o, pulse_power_two_o, pulse_power_three_o;
    logic [2:0] pulse_enable_o;
    logic line_frequency_select_o;
    int bad_count = 0, checked = 0;
    // Per-phase values by source code; apparent row is Vrms*Irms scaled down
    int v[5][3] = '{'{1, 2, 4}, '{16, 32, 64}, '{256, 128, 64}, '{256, 512, 1024}, '{-4096, 8192, 16384}};
    energy_pulse_source_config u_dut (.clock_i, .reset_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
        .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
        .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
        .s_axi_rvalid_o, .s_axi_rready_i, .update_i, .total_active_i, .total_reactive_i, .fund_active_i,
        .fund_reactive_i, .volt_rms_i, .curr_rms_i, .pulse_power_one_o, .pulse_power_two_o,
        .pulse_power_three_o, .pulse_enable_o, .angle_measure_select_o, .line_frequency_select_o);
    always #50 clock_i = ~clock_i;
    // ----------------------------------------------------------------
    // Reference model, compare and bus tasks
    // ----------------------------------------------------------------
    // Expected sum; nominal voltage 0x800000 gives 512 per phase
    function automatic logic signed [25:0] ex(input int c, input logic [2:0] m, input logic [2:0] n);
        int s;
        s = 0;
        for (int p = 0; p < 3; p++)
            if (m[p] && c < 5) s += (c == 2 && n[p]) ? 512 : v[c][p];
        return 26'(s);
    endfunction
    task automatic ck(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("MISMATCH %0t got %h expected %h", $time, g, e);
        end
    endtask
    // Readys are sampled at the falling edge, acted on at the next rise
    task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ka, kw, kb;
        kb = 0;
        @(posedge clock_i);
        s_axi_awaddr_i <= {a, 2'h0};
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'h1;
        s_axi_wvalid_i <= 1'h1;
        s_axi_bready_i <= 1'h1;
        while (!kb)
        begin
            @(negedge clock_i);
            ka = s_axi_awvalid_i && s_axi_awready_o;
            kw = s_axi_wvalid_i && s_axi_wready_o;
            kb = s_axi_bvalid_o;
            r = s_axi_bresp_o;
            @(posedge clock_i);
            if (ka) s_axi_awvalid_i <= 1'h0;
            if (kw) s_axi_wvalid_i <= 1'h0;
        end
        s_axi_bready_i <= 1'h0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ka, kr;
        kr = 0;
        @(posedge clock_i);
        s_axi_araddr_i <= {a, 2'h0};
        s_axi_arvalid_i <= 1'h1;
        s_axi_rready_i <= 1'h1;
        while (!kr)
        begin
            @(negedge clock_i);
            ka = s_axi_arvalid_i && s_axi_arready_o;
            kr = s_axi_rvalid_o;
            d = s_axi_rdata_o;
            r = s_axi_rresp_o;
            @(posedge clock_i);
            if (ka) s_axi_arvalid_i <= 1'h0;
        end
        s_axi_rready_i <= 1'h0;
    endtask
    task automatic rc(input logic [15:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        ck(d, e);
        ck(r, 32'h0);
    endtask
    task automatic up();
        @(posedge clock_i);
        update_i <= 1'h1;
        @(posedge clock_i);
        update_i <= 1'h0;
        @(posedge clock_i);
        @(negedge clock_i);
    endtask
    task automatic co(input int c1, input int c2, input int c3, input logic [2:0] m, input logic [2:0] n);
        ck(pulse_power_one_o, ex(c1, m, n));
        ck(pulse_power_two_o, ex(c2, m, n));
        ck(pulse_power_three_o, ex(c3, m, n));
        ck(pulse_enable_o, {c3 < 5, c2 < 5, c1 < 5});
    endtask
    task automatic close_out();
        if (bad_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Watchdog and test sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (3000) @(posedge clock_i);
        bad_count++;
        close_out();
    end
    initial
    begin
        logic [31:0] d, w;
        logic [1:0] r;
        logic [2:0] m, pm;
        int pc;
        total_active_i = {24'h4, 24'h2, 24'h1};
        total_reactive_i = {24'h40, 24'h20, 24'h10};
        fund_active_i = {24'h400, 24'h200, 24'h100};
        fund_reactive_i = {24'h4000, 24'h2000, 24'hfff000};
        volt_rms_i = {24'h100000, 24'h200000, 24'h400000};
        curr_rms_i = {3{24'h000800}};
        repeat (16) @(posedge clock_i);
        reset_i <= 1'h0;
        rc(CM, 32'h1ff);
        rc(SR, 32'h88);
        rd(16'h0001, d, r);
        ck(d, 32'h0);
        ck(r, 32'h2);
        up();
        co(0, 1, 2, 3'h7, 3'h0);
        pc = 0;
        pm = 3'h7;
        for (int c = 0; c < 8; c++)
        begin
            m = 3'(7 - c);
            w = {17'h0, c[0], 3'h0, c[1:0], m, m, m};
            wr(CM, w, r);
            wr(SR, {23'h0, 3'(c), 3'(c), 3'(c)}, r);
            rc(CM, w);
            rc(SR, {23'h0, 3'(c), 3'(c), 3'(c)});
            ck(pulse_power_one_o, ex(pc, pm, 3'h0));
            up();
            co(c, c, c, m, 3'h0);
            ck(angle_measure_select_o, c[1:0]);
            ck(line_frequency_select_o, c[0]);
            pc = c;
            pm = m;
        end
        wr(NV, 32'h800000, r);
        ck(r, 32'h0);
        rc(NV, 32'h800000);
        wr(CM, 32'h09ff, r);
        wr(SR, 32'h92, r);
        up();
        co(2, 2, 2, 3'h7, 3'h1);
        wr(CM, 32'hb9ff, r);
        up();
        co(2, 2, 2, 3'h7, 3'h7);
        wr(16'h0002, 32'h0, r);
        ck(r, 32'h2);
        rc(CM, 32'hb9ff);
        close_out();
    end
endmodule
`default_nettype wire
